/* svcf_pkg.sv */
package svcf_pkg;
  // Switch geometry and field widths.
  localparam int PORTS = 8;
  localparam int VID_W = 12;
  localparam int VLANS = 4096;
  localparam int FID_W = 6;
  localparam int LEN_W = 14;
  localparam int Q_W = 3;
  localparam int PCP_W = 3;
  localparam int GARP_N = 16;
  localparam int CODE_W = 2;
  localparam int POP_W = 2;

  // Frame recognition constants.
  localparam logic [15:0] CTAG_TPID = 16'h8100;
  localparam logic [43:0] GARP_DMAC_HI = 44'h0180C200002;
  localparam logic [3:0] GVRP_INDEX = 4'h1;
  localparam logic [LEN_W-1:0] TAG_LEN_EXTRA = 14'h0004;
  localparam logic [VID_W-1:0] PRIO_VID = 12'h000;

  // Reset values of the per-VLAN table.
  localparam logic [PORTS-1:0] MEMBER_RESET = 8'hFF;
  localparam logic [FID_W-1:0] FID_RESET = 6'h00;

  // Table command codes.
  localparam logic [1:0] TBL_IDLE = 2'h0;
  localparam logic [1:0] TBL_READ = 2'h1;
  localparam logic [1:0] TBL_WRITE = 2'h2;

  // Egress tagging codes.
  localparam logic [1:0] TAG_NONE = 2'h0;
  localparam logic [1:0] TAG_ONE_UNTAG = 2'h1;
  localparam logic [1:0] TAG_ONE_PRIO = 2'h2;
  localparam logic [1:0] TAG_ALL = 2'h3;

  // Result word layout.
  localparam int RES_FWD = 0;
  localparam int RES_CPU = 1;
  localparam int RES_Q = 2;
  localparam int RES_LRN = 5;
  localparam int RES_DMAC = 6;
  localparam int RES_KEY = 54;
  localparam int RES_TAG = 66;
  localparam int RES_TCI = 67;
  localparam int RES_POP = 83;
  localparam int RES_EP = 85;
  localparam int RES_MD = 88;
  localparam int RES_W = 89;
endpackage : svcf_pkg

/* svcf_skid_buffer.sv */
`timescale 1ns/1ps
// Two-entry buffer: an output register plus one skid slot. Ready is a
// flop so that the upstream timing path stops here.
module svcf_skid_buffer #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Fill side.
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Drain side.
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  logic out_valid_r, out_valid_nxt, skid_valid_r, skid_valid_nxt;
  logic [WIDTH-1:0] out_data_r, out_data_nxt, skid_data_r, skid_data_nxt;
  wire push = i_in_valid & ~skid_valid_r;
  wire drain_free = ~out_valid_r | i_out_ready;

  // Move skid into the output slot first so that word order is kept.
  always_comb begin
    out_valid_nxt = out_valid_r;
    out_data_nxt = out_data_r;
    skid_valid_nxt = skid_valid_r;
    skid_data_nxt = skid_data_r;
    if (drain_free) begin
      if (skid_valid_r) begin
        out_valid_nxt = 1'b1;
        out_data_nxt = skid_data_r;
        skid_valid_nxt = 1'b0;
      end else begin
        out_valid_nxt = push;
        if (push) begin
          out_data_nxt = i_in_data;
        end
      end
    end else if (push) begin
      skid_valid_nxt = 1'b1;
      skid_data_nxt = i_in_data;
    end
  end

  // State flops.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      out_valid_r <= 1'b0;
      skid_valid_r <= 1'b0;
      out_data_r <= '0;
      skid_data_r <= '0;
      o_in_ready <= 1'b1;
    end else begin
      out_valid_r <= out_valid_nxt;
      skid_valid_r <= skid_valid_nxt;
      out_data_r <= out_data_nxt;
      skid_data_r <= skid_data_nxt;
      o_in_ready <= ~skid_valid_nxt;
    end
  end

  assign o_out_valid = out_valid_r;
  assign o_out_data = out_data_r;
endmodule : svcf_skid_buffer

/* svcf_classify_filter.sv */
`timescale 1ns/1ps
// Contract
// - With MAC tag awareness and length allowance on, tagged frames may exceed max length by four bytes.
// - Per-port discard bits drop untagged, priority-tagged or tagged frames.
// - Untagged and priority-tagged frames take port default VID, priority, drop bit.
// - Tag-aware ports classify tagged frames to the tag VID; others ignore tags.
// - Destination lookup uses classified VID or filter id plus destination MAC.
// - All ports belong to all VLANs after reset; table set by index and command.
// - Membership filtering is enabled per ingress port by a mask.
// - Filtered frames from non-member ingress ports are discarded.
// - Each membership discard sets a sticky flag held until software clears it.
// - With learn-check set, membership-discarded frames are not learned.
// - GVRP address frames go to CPU when capture bit one of the port is set.
// - Captured GARP frames use the CPU queue configured for their address.
// - Learning is independent per VLAN unless the shared mask control is set.
// - Shared learning maps each VLAN to one of 64 filter identifiers.
// - Egress code 3 tags all, 0 untags all, 1 untags only the egress_untag_lan_id.
// - Code 2 additionally untags frames received priority-tagged with VID zero.
// - A nonzero per-port count makes the rewriter remove one received tag, whatever the count.
// - A customer tag is recognised by EtherType 0x8100 after the source MAC.
module svcf_classify_filter #(
  parameter int PORTS = svcf_pkg::PORTS,
  parameter int VLANS = svcf_pkg::VLANS
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Ingress frame descriptor.
  input wire logic i_frm_valid,
  output logic o_frm_ready,
  input wire logic [2:0] i_frm_ingress_port,
  input wire logic [2:0] i_frm_egress_port,
  input wire logic [svcf_pkg::LEN_W-1:0] i_frm_length,
  input wire logic [47:0] i_frm_dmac,
  input wire logic [15:0] i_frm_ethertype,
  input wire logic [15:0] i_frm_tci,
  // Per-port MAC configuration.
  input wire logic [PORTS*svcf_pkg::LEN_W-1:0] i_port_max_frame_length,
  input wire logic [PORTS-1:0] i_mac_tag_aware_enable,
  input wire logic [PORTS-1:0] i_mac_tag_length_allow_enable,
  // Per-port ingress configuration.
  input wire logic [PORTS-1:0] i_discard_untagged_enable,
  input wire logic [PORTS-1:0] i_discard_tagged_enable,
  input wire logic [PORTS-1:0] i_discard_priority_tagged_enable,
  input wire logic [PORTS-1:0] i_tag_aware_classify_enable,
  input wire logic [PORTS*svcf_pkg::VID_W-1:0] i_port_default_vlan_id,
  input wire logic [PORTS*svcf_pkg::PCP_W-1:0] i_port_default_priority,
  input wire logic [PORTS-1:0] i_port_default_drop_eligible,
  // Filtering and learning.
  input wire logic [PORTS-1:0] i_ingress_member_filter_enable,
  input wire logic i_skip_learn_on_member_discard,
  input wire logic i_shared_learning_mask,
  input wire logic i_clear_membership_discard,
  output logic o_membership_discard_sticky,
  // GARP capture.
  input wire logic [PORTS*svcf_pkg::GARP_N-1:0] i_garp_capture_enable,
  input wire logic [svcf_pkg::GARP_N*svcf_pkg::Q_W-1:0] i_garp_capture_queue,
  // Egress rewriter configuration.
  input wire logic [PORTS*svcf_pkg::CODE_W-1:0] i_egress_tag_code,
  input wire logic [PORTS*svcf_pkg::VID_W-1:0] i_egress_untag_lan_id,
  input wire logic [PORTS*svcf_pkg::POP_W-1:0] i_tag_remove_count,
  // Per-VLAN table access.
  input wire logic [svcf_pkg::VID_W-1:0] i_lan_table_index,
  input wire logic [1:0] i_lan_table_command,
  input wire logic [PORTS-1:0] i_lan_table_port_mask,
  input wire logic [svcf_pkg::FID_W-1:0] i_lan_table_filter_db_id,
  output logic [PORTS-1:0] o_lan_table_read_mask,
  output logic [svcf_pkg::FID_W-1:0] o_lan_table_read_filter_db_id,
  output logic o_lan_table_done,
  // Result stream.
  output logic o_res_valid,
  input wire logic i_res_ready,
  output logic o_res_forward,
  output logic o_res_to_cpu,
  output logic [svcf_pkg::Q_W-1:0] o_res_cpu_queue,
  output logic o_res_learn,
  output logic [47:0] o_res_lookup_dmac,
  output logic [svcf_pkg::VID_W-1:0] o_res_lookup_key,
  output logic o_res_tx_tagged,
  output logic [15:0] o_res_tx_tci,
  output logic [svcf_pkg::POP_W-1:0] o_res_tag_remove,
  output logic [2:0] o_res_egress_port,
  output logic o_res_member_discard
);
  localparam int VW = svcf_pkg::VID_W;
  localparam int FW = svcf_pkg::FID_W;

  // Single-bit selection by port, used for every per-port flag.
  function automatic logic port_bit(input logic [PORTS-1:0] v, input logic [2:0] p);
    port_bit = v[p];
  endfunction : port_bit

  // Per-VLAN membership and filter identifier storage.
  logic [PORTS-1:0] member_r [0:VLANS-1];
  logic [FW-1:0] fid_r [0:VLANS-1];
  logic sticky_r;
  logic [PORTS-1:0] rd_mask_r;
  logic [FW-1:0] rd_fid_r;
  logic tbl_done_r;
  logic buf_ready;
  logic [svcf_pkg::RES_W-1:0] res_c, res_q;

  wire [2:0] ip = i_frm_ingress_port;
  wire [2:0] ep = i_frm_egress_port;
  wire push = i_frm_valid & buf_ready;

  // Frame type parsing from the EtherType after the source MAC.
  wire tag_rx = (i_frm_ethertype == svcf_pkg::CTAG_TPID);
  wire [VW-1:0] tag_vid = i_frm_tci[VW-1:0];
  wire prio_rx = tag_rx & (tag_vid == svcf_pkg::PRIO_VID);
  wire vtag_rx = tag_rx & ~prio_rx;
  wire untag_rx = ~tag_rx;

  // Length check; the MAC must see the tag for the allowance to apply.
  wire [svcf_pkg::LEN_W-1:0] max_len =
    i_port_max_frame_length[ip*svcf_pkg::LEN_W +: svcf_pkg::LEN_W];
  wire len_allow = tag_rx & port_bit(i_mac_tag_aware_enable, ip) &
    port_bit(i_mac_tag_length_allow_enable, ip);
  wire [svcf_pkg::LEN_W:0] len_limit = {1'b0, max_len} +
    {1'b0, (len_allow ? svcf_pkg::TAG_LEN_EXTRA : 14'h0000)};
  wire len_drop = {1'b0, i_frm_length} > len_limit;

  // Acceptable frame types, one discard bit per kind.
  wire type_drop = (untag_rx & port_bit(i_discard_untagged_enable, ip)) |
    (prio_rx & port_bit(i_discard_priority_tagged_enable, ip)) |
    (vtag_rx & port_bit(i_discard_tagged_enable, ip));
  wire frame_drop = type_drop | len_drop;

  // Classification; priority-tagged frames fall back to the port default.
  wire from_tag = vtag_rx & port_bit(i_tag_aware_classify_enable, ip);
  wire [VW-1:0] def_vid = i_port_default_vlan_id[ip*VW +: VW];
  wire [2:0] def_pcp = i_port_default_priority[ip*svcf_pkg::PCP_W +: svcf_pkg::PCP_W];
  wire def_dei = port_bit(i_port_default_drop_eligible, ip);
  wire [VW-1:0] cls_vid = from_tag ? tag_vid : def_vid;
  wire [2:0] cls_pcp = from_tag ? i_frm_tci[15:13] : def_pcp;
  wire cls_dei = from_tag ? i_frm_tci[12] : def_dei;

  // Membership filter, only counted for frames that survived the length and frame-type checks.
  wire is_member = port_bit(member_r[cls_vid], ip);
  wire member_drop = ~frame_drop & port_bit(i_ingress_member_filter_enable, ip) &
    ~is_member;

  // GARP capture; the low DMAC nibble selects the per-address settings.
  wire [3:0] garp_idx = i_frm_dmac[3:0];
  wire garp_addr = (i_frm_dmac[47:4] == svcf_pkg::GARP_DMAC_HI);
  wire garp_en = i_garp_capture_enable[ip*svcf_pkg::GARP_N + garp_idx];
  wire garp_hit = garp_addr & garp_en & ~frame_drop;
  wire [2:0] garp_q = i_garp_capture_queue[garp_idx*svcf_pkg::Q_W +: svcf_pkg::Q_W];

  // Forwarding and learning decisions.
  wire fwd = ~frame_drop & ~member_drop & ~garp_hit;
  wire learn = ~frame_drop & ~(member_drop & i_skip_learn_on_member_discard);
  wire [VW-1:0] lookup_key = i_shared_learning_mask ?
    {{(VW-FW){1'b0}}, fid_r[cls_vid]} : cls_vid;

  // Egress untag decision for the frame's egress port.
  wire [1:0] tag_code = i_egress_tag_code[ep*svcf_pkg::CODE_W +: svcf_pkg::CODE_W];
  wire [VW-1:0] untag_vid = i_egress_untag_lan_id[ep*VW +: VW];
  wire [1:0] pop_cfg = i_tag_remove_count[ep*svcf_pkg::POP_W +: svcf_pkg::POP_W];
  wire vid_match = (cls_vid == untag_vid);
  wire tx_tag = (tag_code == svcf_pkg::TAG_ALL) |
    ((tag_code == svcf_pkg::TAG_ONE_UNTAG) & ~vid_match) |
    ((tag_code == svcf_pkg::TAG_ONE_PRIO) & ~vid_match & ~prio_rx);
  wire [1:0] pop_eff = (tag_rx && pop_cfg != 2'h0) ? 2'h1 : 2'h0;

  // Pack the result word.
  assign res_c[svcf_pkg::RES_FWD] = fwd;
  assign res_c[svcf_pkg::RES_CPU] = garp_hit;
  assign res_c[svcf_pkg::RES_Q +: svcf_pkg::Q_W] = garp_hit ? garp_q : 3'h0;
  assign res_c[svcf_pkg::RES_LRN] = learn;
  assign res_c[svcf_pkg::RES_DMAC +: 48] = i_frm_dmac;
  assign res_c[svcf_pkg::RES_KEY +: VW] = lookup_key;
  assign res_c[svcf_pkg::RES_TAG] = tx_tag;
  assign res_c[svcf_pkg::RES_TCI +: 16] = {cls_pcp, cls_dei, cls_vid};
  assign res_c[svcf_pkg::RES_POP +: svcf_pkg::POP_W] = pop_eff;
  assign res_c[svcf_pkg::RES_EP +: 3] = ep;
  assign res_c[svcf_pkg::RES_MD] = member_drop;

  // The buffer holds results while the receiver stalls, so no word is lost.
  svcf_skid_buffer #(
    .WIDTH(svcf_pkg::RES_W)
  ) u_res_buf (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_in_valid(i_frm_valid),
    .o_in_ready(buf_ready),
    .i_in_data(res_c),
    .o_out_valid(o_res_valid),
    .i_out_ready(i_res_ready),
    .o_out_data(res_q)
  );

  // A write lands after the lookup of the same cycle sees the old entry.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      for (int v = 0; v < VLANS; v++) begin
        member_r[v] <= svcf_pkg::MEMBER_RESET;
        fid_r[v] <= svcf_pkg::FID_RESET;
      end
    end else if (i_lan_table_command == svcf_pkg::TBL_WRITE) begin
      member_r[i_lan_table_index] <= i_lan_table_port_mask;
      fid_r[i_lan_table_index] <= i_lan_table_filter_db_id;
    end
  end

  // Table read port and completion pulse.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rd_mask_r <= '0;
      rd_fid_r <= '0;
      tbl_done_r <= 1'b0;
    end else begin
      tbl_done_r <= (i_lan_table_command != svcf_pkg::TBL_IDLE);
      if (i_lan_table_command == svcf_pkg::TBL_READ) begin
        rd_mask_r <= member_r[i_lan_table_index];
        rd_fid_r <= fid_r[i_lan_table_index];
      end
    end
  end

  // Sticky discard flag; a new discard beats a clear in the same cycle.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sticky_r <= 1'b0;
    end else begin
      sticky_r <= (push & member_drop) | (sticky_r & ~i_clear_membership_discard);
    end
  end

  // Output mapping, all from flops.
  assign o_frm_ready = buf_ready;
  assign o_membership_discard_sticky = sticky_r;
  assign o_lan_table_read_mask = rd_mask_r;
  assign o_lan_table_read_filter_db_id = rd_fid_r;
  assign o_lan_table_done = tbl_done_r;
  assign o_res_forward = res_q[svcf_pkg::RES_FWD];
  assign o_res_to_cpu = res_q[svcf_pkg::RES_CPU];
  assign o_res_cpu_queue = res_q[svcf_pkg::RES_Q +: svcf_pkg::Q_W];
  assign o_res_learn = res_q[svcf_pkg::RES_LRN];
  assign o_res_lookup_dmac = res_q[svcf_pkg::RES_DMAC +: 48];
  assign o_res_lookup_key = res_q[svcf_pkg::RES_KEY +: VW];
  assign o_res_tx_tagged = res_q[svcf_pkg::RES_TAG];
  assign o_res_tx_tci = res_q[svcf_pkg::RES_TCI +: 16];
  assign o_res_tag_remove = res_q[svcf_pkg::RES_POP +: svcf_pkg::POP_W];
  assign o_res_egress_port = res_q[svcf_pkg::RES_EP +: 3];
  assign o_res_member_discard = res_q[svcf_pkg::RES_MD];

  // Checks on the decisions and the stored state.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  sequence s_tbl_write;
    i_lan_table_command == svcf_pkg::TBL_WRITE;
  endsequence
  sequence s_tbl_read_same;
    i_lan_table_command == svcf_pkg::TBL_READ &&
      i_lan_table_index == $past(i_lan_table_index);
  endsequence

  a_len_allowance: assert property (
    push && tag_rx && port_bit(i_mac_tag_aware_enable, ip) &&
    port_bit(i_mac_tag_length_allow_enable, ip) &&
    {1'b0, i_frm_length} == {1'b0, max_len} + 15'h0004 |-> !len_drop)
    else $error("tagged frame within allowance was dropped");
  a_type_discard: assert property (
    push && untag_rx && port_bit(i_discard_untagged_enable, ip)
    |-> !fwd && !learn)
    else $error("untagged frame not discarded");
  a_default_vid: assert property (
    push && (untag_rx || prio_rx) |-> res_c[svcf_pkg::RES_TCI +: VW] == def_vid)
    else $error("untagged frame not on port default VID");
  a_tag_vid: assert property (
    push && vtag_rx && port_bit(i_tag_aware_classify_enable, ip) |-> cls_vid == tag_vid)
    else $error("aware port ignored tag VID");
  a_member_drop: assert property (
    push && !frame_drop && port_bit(i_ingress_member_filter_enable, ip) &&
    !is_member |-> res_c[svcf_pkg::RES_MD] && !fwd)
    else $error("non-member frame forwarded");
  a_sticky_set: assert property (
    push && member_drop |=> o_membership_discard_sticky)
    else $error("discard did not set sticky flag");
  a_sticky_hold: assert property (
    o_membership_discard_sticky && !i_clear_membership_discard
    |=> o_membership_discard_sticky)
    else $error("sticky flag lost without clear");
  a_learn_skip: assert property (
    push && member_drop && i_skip_learn_on_member_discard |-> !learn)
    else $error("membership-discarded frame learned");
  a_gvrp_capture: assert property (
    push && !frame_drop && i_frm_dmac == 48'h0180C2000021 &&
    i_garp_capture_enable[ip*svcf_pkg::GARP_N + 1] |-> garp_hit &&
    garp_q == i_garp_capture_queue[svcf_pkg::Q_W +: svcf_pkg::Q_W])
    else $error("GVRP frame not sent to CPU queue");
  a_egress_code: assert property (
    push && tag_code == svcf_pkg::TAG_NONE |-> !tx_tag)
    else $error("code zero frame tagged");
  a_prio_untag: assert property (
    push && tag_code == svcf_pkg::TAG_ONE_PRIO && prio_rx |-> !tx_tag)
    else $error("priority-tagged frame kept its tag");
  a_table_rw: assert property (
    s_tbl_write ##1 s_tbl_read_same |=> o_lan_table_read_mask ==
    $past(i_lan_table_port_mask, 2))
    else $error("table read did not return written mask");
  a_res_hold: assert property (
    o_res_valid && !i_res_ready |=> o_res_valid && $stable(o_res_tx_tci))
    else $error("result changed while stalled");

  // Decisions are checked as the word enters the buffer, so a stall cannot hide them.
  a_filter_off: assert property (
    push && !port_bit(i_ingress_member_filter_enable, ip) |-> !member_drop)
    else $error("member discard with filter off");
  a_len_limit: assert property (
    push && !tag_rx && {1'b0, i_frm_length} > {1'b0, max_len} |-> len_drop)
    else $error("overlong untagged frame kept");
  a_type_prio: assert property (
    push && prio_rx && port_bit(i_discard_priority_tagged_enable, ip) |-> !fwd && !learn)
    else $error("priority frame kept");
  a_type_tagged: assert property (
    push && vtag_rx && port_bit(i_discard_tagged_enable, ip) |-> !fwd && !learn)
    else $error("tagged frame kept");
  a_unaware_vid: assert property (
    push && tag_rx && !port_bit(i_tag_aware_classify_enable, ip) |-> cls_vid == def_vid)
    else $error("unaware port used tag VID");
  a_tag_insert: assert property (
    push && vtag_rx && port_bit(i_tag_aware_classify_enable, ip)
    |-> {cls_pcp, cls_dei, cls_vid} == i_frm_tci)
    else $error("tag fields differ");
  a_key_vid: assert property (
    push && !i_shared_learning_mask |-> lookup_key == cls_vid)
    else $error("key not the VID");
  a_key_fid: assert property (
    push && i_shared_learning_mask |-> lookup_key[VW-1:FW] == '0)
    else $error("filter id key out of range");
  a_pop_untag: assert property (
    push && untag_rx |-> pop_eff == 2'h0)
    else $error("tag removed from untagged frame");
  a_tag_all: assert property (
    push && tag_code == svcf_pkg::TAG_ALL |-> tx_tag)
    else $error("code three frame untagged");
  a_untag_match: assert property (
    push && tag_code == svcf_pkg::TAG_ONE_UNTAG && vid_match |-> !tx_tag)
    else $error("egress_untag_lan_id frame kept its tag");
endmodule : svcf_classify_filter

/* svcf_mac_port_model.sv */
`timescale 1ns/1ps
// Result sink standing in for the egress port MACs. It can stall so the buffer gets exercised.
module svcf_mac_port_model (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // Pacing: 0 takes every word, 1 takes at random, 2 stalls.
  input wire logic [1:0] i_mode,
  // Result handshake.
  output logic o_res_ready
);
  // Ready is registered, so a mode change takes effect one cycle later.
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_res_ready <= 1'b0;
    end else begin
      o_res_ready <= (i_mode == 2'h0) || ((i_mode == 2'h1) && 1'($urandom));
    end
  end
endmodule : svcf_mac_port_model

/* svcf_classify_filter_test.sv */
`timescale 1ns/1ps
module svcf_classify_filter_test;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  logic fv = 1'b0, skip = 1'b0, shr = 1'b0, clr = 1'b0, res_ready;
  logic [2:0] fip = '0, fep = '0;
  logic [13:0] flen = '0;
  logic [47:0] fdmac = '0, capq = '0;
  logic [15:0] fet = '0, ftci = '0, code = '0, pop = '0;
  logic [111:0] maxl = {8{14'h05EE}};
  logic [7:0] maw = '0, mla = '0, du = '0, dt = '0, dp = '0, aw = '0, ddei = '0, filt = '0;
  logic [95:0] dvid = '0, uvid = '0;
  logic [23:0] dpcp = '0;
  logic [127:0] cap = '0;
  logic [11:0] tidx = '0;
  logic [1:0] tcmd = '0, mode = '0;
  logic [7:0] tmsk = '0, rdmask;
  logic [5:0] tdb = '0, rddb;
  logic frm_ready, sticky, done, res_valid, fwd, cpu, lrn, txt, md;
  logic [2:0] q, ep;
  logic [47:0] dm;
  logic [11:0] key;
  logic [15:0] tci_o;
  logic [1:0] rm;
  logic [88:0] seen;
  logic [7:0] tmask [4096];
  logic [5:0] tfdb [4096];
  logic [88:0] expq [$];
  int num_errors = 0;
  int num_checks = 0;

  // The 5 ns clock.
  always #2.5 i_clk_sys = ~i_clk_sys;

  // Result fields packed in the package's layout.
  assign seen = {md, ep, rm, tci_o, txt, key, dm, lrn, q, cpu, fwd};

  svcf_classify_filter dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_frm_valid(fv),
    .o_frm_ready(frm_ready), .i_frm_ingress_port(fip), .i_frm_egress_port(fep),
    .i_frm_length(flen), .i_frm_dmac(fdmac), .i_frm_ethertype(fet), .i_frm_tci(ftci),
    .i_port_max_frame_length(maxl), .i_mac_tag_aware_enable(maw),
    .i_mac_tag_length_allow_enable(mla), .i_discard_untagged_enable(du),
    .i_discard_tagged_enable(dt), .i_discard_priority_tagged_enable(dp),
    .i_tag_aware_classify_enable(aw), .i_port_default_vlan_id(dvid),
    .i_port_default_priority(dpcp), .i_port_default_drop_eligible(ddei),
    .i_ingress_member_filter_enable(filt), .i_skip_learn_on_member_discard(skip),
    .i_shared_learning_mask(shr), .i_clear_membership_discard(clr),
    .o_membership_discard_sticky(sticky), .i_garp_capture_enable(cap),
    .i_garp_capture_queue(capq), .i_egress_tag_code(code), .i_egress_untag_lan_id(uvid),
    .i_tag_remove_count(pop), .i_lan_table_index(tidx), .i_lan_table_command(tcmd),
    .i_lan_table_port_mask(tmsk), .i_lan_table_filter_db_id(tdb),
    .o_lan_table_read_mask(rdmask), .o_lan_table_read_filter_db_id(rddb),
    .o_lan_table_done(done), .o_res_valid(res_valid), .i_res_ready(res_ready),
    .o_res_forward(fwd), .o_res_to_cpu(cpu), .o_res_cpu_queue(q), .o_res_learn(lrn),
    .o_res_lookup_dmac(dm), .o_res_lookup_key(key), .o_res_tx_tagged(txt),
    .o_res_tx_tci(tci_o), .o_res_tag_remove(rm), .o_res_egress_port(ep),
    .o_res_member_discard(md));

  svcf_mac_port_model partner (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_mode(mode),
    .o_res_ready(res_ready));

  task automatic check(input logic [88:0] got, input logic [88:0] want, input string what);
    num_checks++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // Reference model of one result, read from the inputs in force at the taking edge.
  function automatic logic [88:0] expect_res();
    logic tg, pr, drop, hit, mdx, tx;
    logic [15:0] tci;
    logic [11:0] vid;
    tg = fet == svcf_pkg::CTAG_TPID;
    pr = tg && ftci[11:0] == svcf_pkg::PRIO_VID;
    drop = {1'b0, flen} > {1'b0, maxl[fip*14+:14]}
      + ((tg && maw[fip] && mla[fip]) ? {1'b0, svcf_pkg::TAG_LEN_EXTRA} : 15'h0000);
    drop = drop | (!tg && du[fip]) | (pr && dp[fip]) | (tg && !pr && dt[fip]);
    tci = (tg && !pr && aw[fip]) ? ftci : {dpcp[fip*3+:3], ddei[fip], dvid[fip*12+:12]};
    vid = tci[11:0];
    hit = !drop && fdmac[47:4] == svcf_pkg::GARP_DMAC_HI && cap[fip*16+fdmac[3:0]];
    mdx = !drop && filt[fip] && !tmask[vid][fip];
    case (code[fep*2+:2])
      svcf_pkg::TAG_NONE: tx = 1'b0;
      svcf_pkg::TAG_ONE_UNTAG: tx = vid != uvid[fep*12+:12];
      svcf_pkg::TAG_ONE_PRIO: tx = vid != uvid[fep*12+:12] && !pr;
      default: tx = 1'b1;
    endcase
    return {mdx, fep, (tg && pop[fep*2+:2] != 2'h0) ? 2'h1 : 2'h0, tci, tx,
      shr ? {6'h00, tfdb[vid]} : vid, fdmac, !drop && !(mdx && skip),
      hit ? capq[fdmac[3:0]*3+:3] : 3'h0, hit, !drop && !mdx && !hit};
  endfunction : expect_res

  // Every accepted result is compared in order against the model.
  always @(posedge i_clk_sys) begin
    if (!i_reset && res_valid && res_ready) begin
      if (expq.size() == 0) check(seen, '1, "extra result");
      else check(seen, expq.pop_front(), "result");
    end
  end

  task automatic tbl(input logic [1:0] c, input logic [11:0] i, input logic [7:0] m,
                     input logic [5:0] f);
    @(posedge i_clk_sys);
    tcmd <= c;
    tidx <= i;
    tmsk <= m;
    tdb <= f;
    @(posedge i_clk_sys);
    tcmd <= svcf_pkg::TBL_IDLE;
    if (c == svcf_pkg::TBL_WRITE) begin
      tmask[i] = m;
      tfdb[i] = f;
    end
    @(negedge i_clk_sys);
    check({88'h0, done}, 89'h1, "table done");
    if (c == svcf_pkg::TBL_READ) check({rdmask, rddb}, {tmask[i], tfdb[i]}, "table read");
  endtask : tbl

  // Presents one descriptor, waits a bounded time for it to be taken, and leaves valid up.
  task automatic send(input bit fixed);
    int n;
    n = 0;
    fv <= 1'b1;
    fip <= fixed ? 3'h0 : 3'($urandom);
    fep <= 3'($urandom);
    flen <= fixed ? 14'h05EA : 14'h05EA + 14'($urandom_range(8, 0));
    fdmac <= ($urandom_range(2, 0) == 0) ? {svcf_pkg::GARP_DMAC_HI, 4'($urandom)}
      : {16'h0000, $urandom};
    fet <= ($urandom_range(2, 0) == 0 || fixed) ? 16'h0800 : svcf_pkg::CTAG_TPID;
    ftci <= {4'($urandom), 12'($urandom_range(7, 0))};
    if (fixed) fdmac <= 48'h000000000100;
    @(negedge i_clk_sys);
    while (!frm_ready && n < 50) begin
      n++;
      @(negedge i_clk_sys);
    end
    if (n == 50) begin
      num_errors++;
      conclude();
    end
    @(posedge i_clk_sys);
    expq.push_back(expect_res());
  endtask : send

  task automatic drain();
    int n;
    fv <= 1'b0;
    for (n = 0; n < 200 && expq.size() != 0; n++) @(posedge i_clk_sys);
    if (expq.size() != 0) begin
      num_errors++;
      conclude();
    end
  endtask : drain

  initial begin
    void'($urandom(32'h5e38));
    foreach (tmask[i]) begin
      tmask[i] = svcf_pkg::MEMBER_RESET;
      tfdb[i] = svcf_pkg::FID_RESET;
    end
    repeat (10) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    @(negedge i_clk_sys);
    check({rdmask, rddb, sticky, res_valid, frm_ready, done}, 89'h2, "after reset");
    tbl(svcf_pkg::TBL_READ, 12'hFFF, 8'h00, 6'h00);
    for (int v = 1; v < 8; v++) begin
      tbl(svcf_pkg::TBL_WRITE, 12'(v), 8'($urandom), 6'($urandom));
      tbl(svcf_pkg::TBL_READ, 12'(v), 8'h00, 6'h00);
    end
    // Random configurations, each with a burst of back-to-back descriptors.
    for (int b = 0; b < 12; b++) begin
      @(posedge i_clk_sys);
      {maw, mla, du, dt, dp, aw, ddei, filt} <= {$urandom, $urandom};
      {skip, shr, code, pop, dpcp} <= {$urandom, $urandom};
      {cap, capq} <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      for (int p = 0; p < 8; p++) begin
        dvid[p*12+:12] <= 12'($urandom_range(7, 0));
        uvid[p*12+:12] <= 12'($urandom_range(7, 0));
      end
      mode <= 2'(b % 2);
      repeat (30) send(1'b0);
      drain();
    end
    // Stalled receiver: two words fill the buffer and the third is refused.
    mode <= 2'h2;
    repeat (3) @(posedge i_clk_sys);
    repeat (2) send(1'b0);
    @(negedge i_clk_sys);
    check({88'h0, frm_ready}, 89'h0, "buffer full");
    @(posedge i_clk_sys);
    mode <= 2'h0;
    drain();
    // Membership discard from a filtered port sets the flag until cleared.
    clr <= 1'b1;
    @(posedge i_clk_sys);
    clr <= 1'b0;
    {du, filt, dvid} <= {8'h00, 8'hFF, {8{12'h001}}};
    // Write then read the same entry on consecutive edges.
    @(posedge i_clk_sys);
    tcmd <= svcf_pkg::TBL_WRITE;
    tidx <= 12'h001;
    tmsk <= 8'hFE;
    tdb <= 6'h00;
    @(posedge i_clk_sys);
    tcmd <= svcf_pkg::TBL_READ;
    tmask[1] = 8'hFE;
    tfdb[1] = 6'h00;
    @(posedge i_clk_sys);
    tcmd <= svcf_pkg::TBL_IDLE;
    @(negedge i_clk_sys);
    check({rdmask, rddb, done}, {8'hFE, 6'h00, 1'b1}, "write then read");
    @(negedge i_clk_sys);
    check({88'h0, sticky}, 89'h0, "cleared");
    @(posedge i_clk_sys);
    send(1'b1);
    drain();
    repeat (5) @(posedge i_clk_sys);
    check({88'h0, sticky}, 89'h1, "sticky held");
    conclude();
  end
endmodule : svcf_classify_filter_test
